// ==== rtl/sfotp_otp_mem.sv ====
// Security area storage: user half writable, factory half fixed, registered read
`timescale 1ns/1ps
module sfotp_otp_mem import sfotp_pkg::*; #(
  parameter int         AW           = SFOTP_OTP_AW,
  parameter logic [7:0] FACTORY_SEED = 8'hA5  // Arbitrary per-device pattern
) (
  // Clock and reset
  input  wire logic          clk_i,
  input  wire logic          rst_b_i,
  input  wire logic          clk_en_i,
  // User half write port
  input  wire logic          wr_en_i,
  input  wire logic [AW-1:0] wr_addr_i,
  input  wire logic [7:0]    wr_data_i,
  // Read port
  input  wire logic [AW-1:0] rd_addr_i,
  output logic      [7:0]    rd_data_o
);
  localparam int HALF = 2 ** (AW - 1);

  logic [7:0]      user_mem [HALF];
  logic [HALF-1:0] written_reg;

  if (AW < 2) begin : g_chk
    $error("sfotp_otp_mem: address width too small");
  end

  // Factory half never changes; only the user half accepts writes
  always_ff @(posedge clk_i) begin
    if (clk_en_i && wr_en_i && !wr_addr_i[AW-1]) begin
      user_mem[wr_addr_i[AW-2:0]] <= wr_data_i;
    end
  end

  // Unwritten user bytes read as erased without needing a cleared array
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      written_reg <= '0;
    end else if (clk_en_i && wr_en_i && !wr_addr_i[AW-1]) begin
      written_reg[wr_addr_i[AW-2:0]] <= 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rd_data_o <= 8'h00;
    end else if (clk_en_i) begin
      if (rd_addr_i[AW-1]) begin
        rd_data_o <= FACTORY_SEED ^ 8'(rd_addr_i);
      end else if (written_reg[rd_addr_i[AW-2:0]]) begin
        rd_data_o <= user_mem[rd_addr_i[AW-2:0]];
      end else begin
        rd_data_o <= SFOTP_ERASED;
      end
    end
  end
endmodule

// ==== rtl/sfotp_pkg.sv ====
// Shared constants and types of the serial flash security-area and status read path
package sfotp_pkg;

  // Command opcodes
  localparam logic [7:0] SFOTP_OP_OTP_READ    = 8'h77;
  localparam logic [7:0] SFOTP_OP_STATUS_READ = 8'h05;

  // Header byte counts as last index of a 2-bit counter; bits per byte as last index of a 3-bit one
  localparam logic [1:0] SFOTP_ADDR_LAST  = 2'h2;
  localparam logic [1:0] SFOTP_DUMMY_LAST = 2'h1;
  localparam logic [2:0] SFOTP_BIT_LAST   = 3'h7;

  // Security area geometry
  localparam int         SFOTP_OTP_AW    = 7;
  localparam logic [6:0] SFOTP_OTP_FIRST = 7'h00;
  localparam logic [6:0] SFOTP_OTP_LAST  = 7'h7F;
  localparam logic [7:0] SFOTP_ERASED    = 8'hFF;

  // Status byte 1 field positions
  localparam int SB1_PROT_LOCK = 7;
  localparam int SB1_RSVD      = 6;
  localparam int SB1_EPE       = 5;
  localparam int SB1_WPP       = 4;
  localparam int SB1_SWP_LO    = 2;
  localparam int SB1_WEL       = 1;
  localparam int SB1_BUSY      = 0;

  // Status byte 2 field positions
  localparam int SB2_RST_EN  = 4;
  localparam int SB2_LOCK_EN = 3;
  localparam int SB2_PS      = 2;
  localparam int SB2_ES      = 1;
  localparam int SB2_BUSY    = 0;

  // Values after reset
  localparam logic       SFOTP_PROT_LOCK_RST = 1'b0;
  localparam logic [1:0] SFOTP_SWP_RST       = 2'h3;
  localparam logic       SFOTP_WEL_RST       = 1'b0;
  localparam logic [3:0] SFOTP_SYNC_RST      = 4'h9;

  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_CMD    = 3'b001,
    ST_ADDR   = 3'b010,
    ST_DUMMY  = 3'b011,
    ST_OTP    = 3'b100,
    ST_STATUS = 3'b101,
    ST_IGNORE = 3'b110
  } sfotp_state_t;

  // Assemble one status byte from its fields
  function automatic logic [7:0] sfotp_status_byte(
    input logic       second,
    input logic       lock,
    input logic       erase_program_error_flag,
    input logic       protect_pin_state,
    input logic [1:0] software_protect_summary,
    input logic       write_enable_latch,
    input logic       busy,
    input logic [3:0] b2_flags
  );
    logic [7:0] b;
    b = 8'h00;
    if (second) begin
      b[SB2_RST_EN]  = b2_flags[3];
      b[SB2_LOCK_EN] = b2_flags[2];
      b[SB2_PS]      = b2_flags[1];
      b[SB2_ES]      = b2_flags[0];
      b[SB2_BUSY]    = busy;
    end else begin
      b[SB1_PROT_LOCK]           = lock;
      b[SB1_EPE]                 = erase_program_error_flag;
      b[SB1_WPP]                 = protect_pin_state;
      b[SB1_SWP_LO+1:SB1_SWP_LO] = software_protect_summary;
      b[SB1_WEL]                 = write_enable_latch;
      b[SB1_BUSY]                = busy;
    end
    return b;
  endfunction

endpackage

// ==== rtl/sfotp_spi_top.sv ====
// SPI command path serving security-area read and status read
`timescale 1ns/1ps
module sfotp_spi_top import sfotp_pkg::*; #(
  parameter logic [7:0] FACTORY_SEED = 8'hA5  // Arbitrary per-device pattern
) (
  // Clock, reset, enable
  input  wire logic       clk_i,
  input  wire logic       rst_b_i,
  input  wire logic       clk_en_i,
  // SPI pins
  input  wire logic       spi_cs_b_i,
  input  wire logic       spi_sck_i,
  input  wire logic       spi_mosi_i,
  output logic            spi_miso_o,
  output logic            spi_miso_oe_o,
  // Write-protect pin, active low
  input  wire logic       wp_b_i,
  // Device state from the core
  input  wire logic       ready_busy_flag_i,
  input  wire logic       erase_program_error_flag_i,
  input  wire logic [1:0] software_protect_summary_i,
  input  wire logic       reset_cmd_enable_i,
  input  wire logic       lockdown_cmd_enable_i,
  input  wire logic       program_suspended_flag_i,
  input  wire logic       erase_suspended_flag_i,
  // Write enable latch control
  input  wire logic       wel_set_i,
  input  wire logic       wel_clr_i,
  input  wire logic       reset_op_i,
  // Status byte 1 write
  input  wire logic       prot_lock_wr_i,
  input  wire logic       prot_lock_wdata_i,
  // Security area user-half write
  input  wire logic       otp_wr_en_i,
  input  wire logic [6:0] otp_wr_addr_i,
  input  wire logic [7:0] otp_wr_data_i,
  // Status byte 1 view
  output logic [7:0]      status_byte_one_o
);

  logic         cs_b_s;
  logic         sck_s;
  logic         mosi_s;
  logic         wp_b_s;
  logic         sck_d_reg;
  logic         sck_rise;
  logic         sck_fall;
  logic [2:0]   bit_cnt_reg;
  logic [7:0]   in_shift_reg;
  logic [7:0]   byte_in;
  logic         byte_end;
  sfotp_state_t state_reg;
  logic [1:0]   byte_cnt_reg;
  logic [6:0]   otp_addr_reg;
  logic [7:0]   otp_rdata;
  logic [2:0]   out_cnt_reg;
  logic [7:0]   out_shift_reg;
  logic         stat_sel_reg;
  logic         out_phase;
  logic         load;
  logic [7:0]   next_byte;
  logic         prot_lock_reg;
  logic         wel_reg;
  logic [1:0]   swp_reg;
  logic [3:0]   b2_flags;

  // Pins cross into the clock domain; the link clock is only sampled
  sfotp_sync #(
    .W       (4),
    .RST_VAL (SFOTP_SYNC_RST)
  ) u_sync (
    .clk_i    (clk_i),
    .rst_b_i  (rst_b_i),
    .clk_en_i (clk_en_i),
    .async_i  ({spi_cs_b_i, spi_sck_i, spi_mosi_i, wp_b_i}),
    .sync_o   ({cs_b_s, sck_s, mosi_s, wp_b_s})
  );

  sfotp_otp_mem #(
    .AW           (SFOTP_OTP_AW),
    .FACTORY_SEED (FACTORY_SEED)
  ) u_mem (
    .clk_i     (clk_i),
    .rst_b_i   (rst_b_i),
    .clk_en_i  (clk_en_i),
    .wr_en_i   (otp_wr_en_i),
    .wr_addr_i (otp_wr_addr_i),
    .wr_data_i (otp_wr_data_i),
    .rd_addr_i (otp_addr_reg),
    .rd_data_o (otp_rdata)
  );

  // Edge detection on the synchronised serial clock
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sck_d_reg <= 1'b0;
    end else if (clk_en_i) begin
      sck_d_reg <= sck_s;
    end
  end

  assign sck_rise = sck_s && !sck_d_reg;
  assign sck_fall = !sck_s && sck_d_reg;
  assign byte_in  = {in_shift_reg[6:0], mosi_s};
  assign byte_end = sck_rise && !cs_b_s && (bit_cnt_reg == SFOTP_BIT_LAST);

  // Input shifter, MSB first on rising edges
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      bit_cnt_reg  <= 3'h0;
      in_shift_reg <= 8'h00;
    end else if (clk_en_i) begin
      if (cs_b_s) begin
        bit_cnt_reg  <= 3'h0;
        in_shift_reg <= 8'h00;
      end else if (sck_rise) begin
        in_shift_reg <= byte_in;
        bit_cnt_reg  <= bit_cnt_reg + 3'h1;
      end
    end
  end

  // Command sequencer and security address
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg    <= ST_IDLE;
      byte_cnt_reg <= 2'h0;
      otp_addr_reg <= SFOTP_OTP_FIRST;
    end else if (clk_en_i) begin
      if (cs_b_s) begin
        state_reg    <= ST_IDLE;
        byte_cnt_reg <= 2'h0;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            state_reg <= ST_CMD;
          end
          ST_CMD: begin
            if (byte_end) begin
              byte_cnt_reg <= 2'h0;
              if (byte_in == SFOTP_OP_OTP_READ) begin
                state_reg <= ST_ADDR;
              end else if (byte_in == SFOTP_OP_STATUS_READ) begin
                state_reg <= ST_STATUS;
              end else begin
                state_reg <= ST_IGNORE;
              end
            end
          end
          ST_ADDR: begin
            if (byte_end) begin
              if (byte_cnt_reg == SFOTP_ADDR_LAST) begin
                // Upper address bits are don't-care
                otp_addr_reg <= byte_in[6:0];
                byte_cnt_reg <= 2'h0;
                state_reg    <= ST_DUMMY;
              end else begin
                byte_cnt_reg <= byte_cnt_reg + 2'h1;
              end
            end
          end
          ST_DUMMY: begin
            if (byte_end) begin
              if (byte_cnt_reg == SFOTP_DUMMY_LAST) begin
                state_reg <= ST_OTP;
              end else begin
                byte_cnt_reg <= byte_cnt_reg + 2'h1;
              end
            end
          end
          ST_OTP: begin
            // Seven-bit address wraps 7Fh to 00h with no extra cycle
            if (load) begin
              otp_addr_reg <= otp_addr_reg + 7'h01;
            end
          end
          ST_STATUS: begin
            state_reg <= ST_STATUS;
          end
          ST_IGNORE: begin
            state_reg <= ST_IGNORE;
          end
          default: begin
            state_reg <= ST_IGNORE;
          end
        endcase
      end
    end
  end

  assign b2_flags  = {reset_cmd_enable_i, lockdown_cmd_enable_i,
                      program_suspended_flag_i, erase_suspended_flag_i};
  assign out_phase = (state_reg == ST_OTP) || (state_reg == ST_STATUS);
  assign load      = sck_fall && !cs_b_s && out_phase && (out_cnt_reg == 3'h0);

  // Status is built from live fields at each byte start
  // Every byte is valid from the first, so hosts keeping four bytes lose nothing
  assign next_byte = (state_reg == ST_OTP) ? otp_rdata :
                     sfotp_status_byte(stat_sel_reg, prot_lock_reg,
                                       erase_program_error_flag_i, wp_b_s,
                                       swp_reg, wel_reg, ready_busy_flag_i,
                                       b2_flags);

  // Output shifter, changes on falling edges and clears on select release
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      spi_miso_o    <= 1'b0;
      spi_miso_oe_o <= 1'b0;
      out_cnt_reg   <= 3'h0;
      out_shift_reg <= 8'h00;
      stat_sel_reg  <= 1'b0;
    end else if (clk_en_i) begin
      if (cs_b_s) begin
        spi_miso_oe_o <= 1'b0;
        spi_miso_o    <= 1'b0;
        out_cnt_reg   <= 3'h0;
        stat_sel_reg  <= 1'b0;
      end else if (sck_fall && out_phase) begin
        spi_miso_oe_o <= 1'b1;
        out_cnt_reg   <= out_cnt_reg + 3'h1;
        if (out_cnt_reg == 3'h0) begin
          spi_miso_o    <= next_byte[7];
          out_shift_reg <= {next_byte[6:0], 1'b0};
          if (state_reg == ST_STATUS) begin
            stat_sel_reg <= !stat_sel_reg;
          end
        end else begin
          spi_miso_o    <= out_shift_reg[7];
          out_shift_reg <= {out_shift_reg[6:0], 1'b0};
        end
      end
    end
  end

  // Protection lock: freely written with the pin high, only set while low
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      prot_lock_reg <= SFOTP_PROT_LOCK_RST;
    end else if (clk_en_i && prot_lock_wr_i) begin
      if (wp_b_s || prot_lock_wdata_i) begin
        prot_lock_reg <= prot_lock_wdata_i;
      end
    end
  end

  // Write enable latch; a set in the same cycle as a clear wins
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wel_reg <= SFOTP_WEL_RST;
    end else if (clk_en_i) begin
      if (wel_set_i) begin
        wel_reg <= 1'b1;
      end else if (wel_clr_i || reset_op_i) begin
        wel_reg <= 1'b0;
      end
    end
  end

  // Software protect summary held so it shows all-protected out of reset
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      swp_reg <= SFOTP_SWP_RST;
    end else if (clk_en_i) begin
      swp_reg <= software_protect_summary_i;
    end
  end

  // Status byte 1 view; reserved bit 6 stays zero
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      status_byte_one_o <= 8'h00;
    end else if (clk_en_i) begin
      status_byte_one_o <= sfotp_status_byte(1'b0, prot_lock_reg,
                                             erase_program_error_flag_i, wp_b_s,
                                             swp_reg, wel_reg, ready_busy_flag_i,
                                             b2_flags);
    end
  end

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  AST_CS_RELEASE_FLOATS: assert property (
    clk_en_i && cs_b_s |=> !spi_miso_oe_o)
    else $error("serial out still driven after select release");
  AST_NO_OUT_IN_HEADER: assert property (
    state_reg inside {ST_IDLE, ST_CMD, ST_ADDR, ST_DUMMY} |-> !spi_miso_oe_o)
    else $error("serial out driven before data phase");
  AST_OTP_OPCODE: assert property (
    clk_en_i && byte_end && state_reg == ST_CMD && byte_in == SFOTP_OP_OTP_READ
    |=> state_reg == ST_ADDR)
    else $error("security read opcode not taken");
  AST_DUMMY_BEFORE_DATA: assert property (
    $rose(state_reg == ST_OTP)
    |-> $past(state_reg) == ST_DUMMY && $past(byte_cnt_reg) == SFOTP_DUMMY_LAST)
    else $error("data phase entered without two dummy bytes");
  AST_OTP_FIRST_BIT: assert property (
    clk_en_i && load && state_reg == ST_OTP
    |=> spi_miso_o == $past(otp_rdata[7]) && spi_miso_oe_o)
    else $error("security byte MSB not driven");
  AST_OTP_ADVANCE: assert property (
    clk_en_i && load && state_reg == ST_OTP
    |=> otp_addr_reg == $past(otp_addr_reg) + 7'h01)
    else $error("security address did not advance");
  AST_OTP_WRAP: assert property (
    clk_en_i && load && state_reg == ST_OTP && otp_addr_reg == SFOTP_OTP_LAST
    |=> otp_addr_reg == SFOTP_OTP_FIRST)
    else $error("security address did not wrap to zero");
  AST_STATUS_ANYTIME: assert property (
    clk_en_i && byte_end && state_reg == ST_CMD && byte_in == SFOTP_OP_STATUS_READ
    |=> state_reg == ST_STATUS)
    else $error("status read opcode not taken");
  AST_STATUS_ALTERNATE: assert property (
    clk_en_i && load && state_reg == ST_STATUS |=> stat_sel_reg != $past(stat_sel_reg))
    else $error("status bytes did not alternate");
  AST_STATUS_BUSY_FRESH: assert property (
    clk_en_i && load && state_reg == ST_STATUS
    |=> out_shift_reg[1] == $past(ready_busy_flag_i))
    else $error("busy bit not refreshed at byte start");
  AST_WPP_RSVD: assert property (
    clk_en_i |=> status_byte_one_o[SB1_WPP] == $past(wp_b_s)
                 && !status_byte_one_o[SB1_RSVD])
    else $error("pin mirror or reserved bit wrong");
  AST_LOCK_ONLY_BY_WRITE: assert property (
    clk_en_i && !prot_lock_wr_i |=> $stable(prot_lock_reg))
    else $error("protection lock changed without write");
  AST_WEL_CLEARED: assert property (
    clk_en_i && reset_op_i && !wel_set_i |=> !wel_reg)
    else $error("write enable latch not cleared");
  AST_OUT_ON_FALL: assert property (
    $changed(spi_miso_o) && spi_miso_oe_o |-> $past(sck_fall))
    else $error("serial out changed off a falling edge");

  COV_OTP_WRAP: cover property (
    load && state_reg == ST_OTP && otp_addr_reg == SFOTP_OTP_LAST);
  COV_STATUS_REPEAT: cover property (
    load && state_reg == ST_STATUS && stat_sel_reg ##[1:100] load);
  COV_MIDBYTE_RELEASE: cover property (
    out_phase && out_cnt_reg != 3'h0 && cs_b_s);
endmodule

// ==== rtl/sfotp_sync.sv ====
// Two-stage synchroniser for pins arriving from outside the clock domain
`timescale 1ns/1ps
module sfotp_sync #(
  parameter int           W       = 4,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Clock and reset
  input  wire logic         clk_i,
  input  wire logic         rst_b_i,
  input  wire logic         clk_en_i,
  // Pins in, synchronised out
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);
  logic [W-1:0] meta_reg;

  if (W < 1) begin : g_chk
    $error("sfotp_sync: width must be positive");
  end

  // First stage feeds only the second
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      meta_reg <= RST_VAL;
      sync_o   <= RST_VAL;
    end else if (clk_en_i) begin
      meta_reg <= async_i;
      sync_o   <= meta_reg;
    end
  end
endmodule

// ==== test/sfotp_host_model.sv ====
// Host SPI controller model, mode 0, paced from the system clock
`timescale 1ns/1ps
module sfotp_host_model (
  // System clock
  input  wire logic clk_i,
  // Device serial out
  input  wire logic miso_i,
  input  wire logic miso_oe_i,
  // SPI pins to the device
  output logic      cs_b_o,
  output logic      sck_o,
  output logic      mosi_o
);
  // Clock stands low outside frames
  initial begin
    cs_b_o = 1'b1;
    sck_o  = 1'b0;
    mosi_o = 1'b0;
  end
  // Select falls a half period ahead of the first rise
  task automatic start();
    @(negedge clk_i);
    cs_b_o = 1'b0;
  endtask
  // Data set while low; read late in the high phase, well clear of the next change
  task automatic xfer_bits(input logic [7:0] tx, input int n,
                           output logic [7:0] rx, output logic oe);
    rx = 8'h00;
    oe = 1'b0;
    for (int i = 7; i > 7 - n; i--) begin
      mosi_o = tx[i];
      repeat (4) @(negedge clk_i);
      sck_o = 1'b1;
      repeat (3) @(negedge clk_i);
      // A released line reads as the inverse, so a missing drive shows up
      rx[i] = miso_oe_i ? miso_i : !miso_i;
      oe    = oe | miso_oe_i;
      @(negedge clk_i);
      sck_o = 1'b0;
    end
  endtask
  // Release may fall mid-byte; input line no longer holds its value
  task automatic stop();
    repeat (2) @(negedge clk_i);
    cs_b_o = 1'b1;
    mosi_o = ~mosi_o;
    repeat (8) @(negedge clk_i);
  endtask
endmodule

// ==== test/tb.sv ====
// Self-checking bench for the security-area and status read path
`timescale 1ns/1ps
module tb import sfotp_pkg::*; ();
  localparam logic [7:0] SEED = 8'h5A;  // Arbitrary per-device pattern
  logic       clk, rst_b, cs_b, sck, mosi, miso, miso_oe, wp_b;
  logic       busy, erase_program_error_flag, rst_en, lock_en, ps, es;
  logic       wel_set, wel_clr, reset_op, lock_wr, lock_wd, otp_wr;
  logic [1:0] software_protect_summary;
  logic [6:0] otp_addr;
  logic [7:0] otp_data, sb1;
  int         failures, n_checks;

  sfotp_spi_top #(.FACTORY_SEED(SEED)) u_sfotp_spi_top (
    .clk_i(clk), .rst_b_i(rst_b), .clk_en_i(1'b1),
    .spi_cs_b_i(cs_b), .spi_sck_i(sck), .spi_mosi_i(mosi),
    .spi_miso_o(miso), .spi_miso_oe_o(miso_oe), .wp_b_i(wp_b),
    .ready_busy_flag_i(busy), .erase_program_error_flag_i(erase_program_error_flag),
    .software_protect_summary_i(software_protect_summary), .reset_cmd_enable_i(rst_en),
    .lockdown_cmd_enable_i(lock_en), .program_suspended_flag_i(ps),
    .erase_suspended_flag_i(es), .wel_set_i(wel_set), .wel_clr_i(wel_clr),
    .reset_op_i(reset_op), .prot_lock_wr_i(lock_wr), .prot_lock_wdata_i(lock_wd),
    .otp_wr_en_i(otp_wr), .otp_wr_addr_i(otp_addr), .otp_wr_data_i(otp_data),
    .status_byte_one_o(sb1));

  sfotp_host_model u_sfotp_host_model (
    .clk_i(clk), .miso_i(miso), .miso_oe_i(miso_oe),
    .cs_b_o(cs_b), .sck_o(sck), .mosi_o(mosi));

  task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic finish_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // Status read: opcode then bytes 1 and 2 alternating, twice round
  task automatic t_status(input logic [7:0] b1, input logic [7:0] b2);
    logic [7:0] rx;
    logic       oe;
    u_sfotp_host_model.start();
    u_sfotp_host_model.xfer_bits(SFOTP_OP_STATUS_READ, 8, rx, oe);
    check("oe_in_opcode", 8'h00, {7'h00, oe});
    for (int k = 0; k < 2; k++) begin
      u_sfotp_host_model.xfer_bits(8'h00, 8, rx, oe);
      check("status_b1", b1, rx);
      check("oe_in_data", 8'h01, {7'h00, oe});
      u_sfotp_host_model.xfer_bits(8'h00, 8, rx, oe);
      check("status_b2", b2, rx);
    end
    u_sfotp_host_model.stop();
  endtask

  // Busy and other fields change; status must follow byte by byte
  task automatic t_live();
    logic [7:0] rx;
    logic       oe;
    wp_b = 1'b0;
    erase_program_error_flag = 1'b1;
    software_protect_summary = 2'h1;
    busy = 1'b1;
    lock_en = 1'b1;
    es = 1'b1;
    rst_en = 1'b0;
    ps = 1'b0;
    wel_set = 1'b1;
    lock_wr = 1'b1;
    lock_wd = 1'b1;
    @(negedge clk);
    wel_set = 1'b0;
    lock_wr = 1'b0;
    repeat (4) @(negedge clk);
    check("sb1_port", 8'hA7, sb1);
    u_sfotp_host_model.start();
    u_sfotp_host_model.xfer_bits(SFOTP_OP_STATUS_READ, 8, rx, oe);
    u_sfotp_host_model.xfer_bits(8'h00, 8, rx, oe);
    check("busy_b1", 8'hA7, rx);
    u_sfotp_host_model.xfer_bits(8'h00, 8, rx, oe);
    busy = 1'b0;
    check("busy_b2", 8'h0B, rx);
    u_sfotp_host_model.xfer_bits(8'h00, 8, rx, oe);
    check("ready_b1", 8'hA6, rx);
    u_sfotp_host_model.stop();
    reset_op = 1'b1;
    @(negedge clk);
    reset_op = 1'b0;
    repeat (2) @(negedge clk);
    check("wel_after_reset_op", 8'hA4, sb1);
  endtask

  // Security read from a high address that wraps past the last location
  task automatic t_otp();
    logic [7:0] rx, hdr [6], exp [4];
    logic       oe, any;
    hdr = '{SFOTP_OP_OTP_READ, 8'hFF, 8'hFF, 8'hFE, 8'h00, 8'h00};
    exp = '{SEED ^ 8'h7E, SEED ^ 8'h7F, 8'h3C, 8'hFF};
    otp_wr = 1'b1;
    otp_addr = 7'h00;
    otp_data = 8'h3C;
    @(negedge clk);
    otp_wr = 1'b0;
    any = 1'b0;
    u_sfotp_host_model.start();
    foreach (hdr[i]) begin
      u_sfotp_host_model.xfer_bits(hdr[i], 8, rx, oe);
      any = any | oe;
    end
    check("oe_in_header", 8'h00, {7'h00, any});
    foreach (exp[i]) begin
      u_sfotp_host_model.xfer_bits(8'h00, 8, rx, oe);
      check("otp_data", exp[i], rx);
    end
    u_sfotp_host_model.xfer_bits(8'h00, 3, rx, oe);
    u_sfotp_host_model.stop();
    check("oe_after_otp", 8'h00, {7'h00, miso_oe});
  endtask

  // Status read cut mid-byte, then an unknown opcode stays silent
  task automatic t_abort();
    logic [7:0] rx;
    logic       oe;
    u_sfotp_host_model.start();
    u_sfotp_host_model.xfer_bits(SFOTP_OP_STATUS_READ, 8, rx, oe);
    u_sfotp_host_model.xfer_bits(8'h00, 3, rx, oe);
    u_sfotp_host_model.stop();
    check("oe_after_abort", 8'h00, {6'h00, miso_oe, miso});
    u_sfotp_host_model.start();
    u_sfotp_host_model.xfer_bits(8'h3A, 8, rx, oe);
    u_sfotp_host_model.xfer_bits(8'h00, 8, rx, oe);
    u_sfotp_host_model.stop();
    check("oe_unknown_op", 8'h00, {7'h00, oe});
  endtask

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    finish_test();
  end

  initial begin
    {rst_b, busy, erase_program_error_flag, lock_en, es, wel_set, wel_clr, reset_op} = '0;
    {lock_wr, lock_wd, otp_wr} = '0;
    {wp_b, rst_en, ps} = 3'h7;
    software_protect_summary = 2'h3;
    otp_addr = 7'h00;
    otp_data = 8'h00;
    failures = 0;
    n_checks = 0;
    repeat (8) @(negedge clk);
    rst_b = 1'b1;
    repeat (4) @(negedge clk);
    check("sb1_reset", 8'h1C, sb1);
    t_status(8'h1C, 8'h14);
    t_live();
    t_otp();
    t_abort();
    wel_set = 1'b1;
    @(negedge clk);
    wel_set = 1'b0;
    wel_clr = 1'b1;
    @(negedge clk);
    wel_clr = 1'b0;
    t_status(8'hA4, 8'h0A);
    finish_test();
  end
endmodule
